/* File: sim/ext_device.sv */
// Purpose: behavioural special device on the system bus
// Assumes: selected by the resource id lines alone
// Notes:   bus_addr only indexes a small word store
`timescale 1ns/10ps

module ext_device #(
    parameter [3:0] MY_RID = 4'hA
) (
    input  wire        clk_sys, rst, bus_req, bus_tbst, bus_write,
    input  wire        bus_dout_en,
    input  wire [2:0]  bus_tsize,
    input  wire [31:0] bus_addr, bus_dout,
    input  wire [3:0]  slow,
    output reg         bus_addr_ack = 1'h0,
    output reg         bus_data_ack = 1'h0,
    output reg  [31:0] bus_din = 32'h0
);
    reg [31:0] mem [0:15];
    reg [3:0]  idx;
    reg        wr;

    always begin
        @(posedge clk_sys);
        // address is an operand only, rid selects
        if (!rst && bus_req && {bus_tbst, bus_tsize} == MY_RID) begin
            idx = bus_addr[5:2];
            wr  = bus_write;
            repeat (slow) @(posedge clk_sys);
            bus_addr_ack <= 1'h1;
            @(posedge clk_sys);
            bus_addr_ack <= 1'h0;
            repeat (slow + 1) @(posedge clk_sys);
            bus_data_ack <= 1'h1;
            if (!wr)
                bus_din <= mem[idx];
            @(posedge clk_sys);
            bus_data_ack <= 1'h0;
            // released lines must not look like valid data
            bus_din <= ~bus_din;
            if (wr && bus_dout_en)
                mem[idx] = bus_dout;
        end
    end
endmodule // ext_device

/* File: sim/memctl_unit_assertions.sv */
// Purpose: port-level checks for memctl_unit
// Assumes: sees only the unit's ports; mirrors access and config regs
// Notes:   direct-store bits mirrored from move-to-segment requests
`timescale 1ns/10ps
`include "memctl_defs.vh"

module memctl_checker (
    input wire        clk_sys, rst, reg_wr, req, busy, done, ctx_sync,
    input wire        arch_update, fetch_redirect, dc_inval, dc_writeback,
    input wire        touch_fill, bus_req, bus_tbst, bus_write, bus_bcast,
    input wire        bus_dout_en, bus_data_ack, dc_hit, bat_prot_viol,
    input wire        tlb_prot_viol,
    input wire [3:0]  reg_addr, req_op, req_seg,
    input wire [2:0]  bus_tsize, exc_code,
    input wire [1:0]  dc_new_state,
    input wire [31:0] reg_wdata, req_ea, req_src, bus_dout, bus_din, result
);
    // ----------------------------------------------------------------
    // mirrors
    // ----------------------------------------------------------------
    wire       go    = req && !busy;
    wire       ec_op = (req_op == `OP_ECIN) || (req_op == `OP_ECOUT);
    wire       dcinv = (req_op == `OP_DCINV);
    wire       viol  = bat_prot_viol || tlb_prot_viol;
    reg [31:0] ear_ff, cfg_ff, src_ff;
    reg [15:0] ds_ff;
    reg [3:0]  op_ff;

    always @(posedge clk_sys) begin
        if (rst) begin
            ear_ff <= `EAR_RESET;
            cfg_ff <= `CFG_RESET;
            ds_ff  <= 16'h0;
            op_ff  <= 4'h0;
            src_ff <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_EXT_ACCESS)
                ear_ff <= reg_wdata;
            if (reg_wr && reg_addr == `ADDR_CONFIG0)
                cfg_ff <= reg_wdata;
            if (go && req_op == `OP_MTSEG)
                ds_ff[req_seg] <= req_src[`SEG_DIRECT_STORE];
            if (go) begin
                op_ff  <= req_op;
                src_ff <= req_src;
            end
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_rid;
        bus_req && (op_ff == `OP_ECIN || op_ff == `OP_ECOUT)
            |-> {bus_tbst, bus_tsize} == ear_ff[`EAR_RID_HI:`EAR_RID_LO];
    endproperty
    a_rid: assert property (p_rid) else $error("rid lines wrong");

    property p_align;
        go && ec_op && req_ea[1:0] != 2'h0 && !ds_ff[req_seg]
            |=> done && exc_code == `EXC_ALIGN && !bus_req;
    endproperty
    a_align: assert property (p_align) else $error("no align fault");

    property p_dstore;
        go && ec_op && req_ea[1:0] == 2'h0 && ds_ff[req_seg]
            |=> done && exc_code == `EXC_DSTORE && !bus_req;
    endproperty
    a_dstore: assert property (p_dstore) else $error("no dsi fault");

    property p_touch;
        go && (req_op == `OP_TOUCH || req_op == `OP_TOUCHST)
            && cfg_ff[`CFG_TOUCH_NOOP] |=> done && !touch_fill && !bus_req;
    endproperty
    a_touch: assert property (p_touch) else $error("touch not noop");

    property p_sys;
        go && req_op == `OP_SYSCALL
            |=> done && ctx_sync && exc_code == `EXC_SYSCALL;
    endproperty
    a_sys: assert property (p_sys) else $error("syscall wrong");

    property p_rfi;
        go && req_op == `OP_RETINT
            |=> ctx_sync && arch_update && !done ##1 done && fetch_redirect;
    endproperty
    a_rfi: assert property (p_rfi) else $error("rfi order wrong");

    property p_inval;
        go && dcinv && dc_hit && !viol && !ds_ff[req_seg]
            |=> dc_inval && dc_new_state == `STATE_INVALID && !dc_writeback;
    endproperty
    a_inval: assert property (p_inval) else $error("no invalidate");

    property p_bcast;
        bus_bcast |-> cfg_ff[`CFG_ADDR_BCAST] && op_ff == `OP_DCINV;
    endproperty
    a_bcast: assert property (p_bcast) else $error("stray bcast");

    property p_viol;
        go && dcinv && viol |=> done && exc_code == `EXC_DSTORE;
    endproperty
    a_viol: assert property (p_viol) else $error("viol not dsi");

    property p_dsnop;
        go && dcinv && ds_ff[req_seg] |=> !dc_inval && !bus_bcast;
    endproperty
    a_dsnop: assert property (p_dsnop) else $error("ds not noop");

    property p_dout;
        bus_dout_en |-> bus_write && bus_dout == src_ff;
    endproperty
    a_dout: assert property (p_dout) else $error("bad out word");

    property p_din;
        bus_data_ack && busy && op_ff == `OP_ECIN
            |=> done && result == $past(bus_din);
    endproperty
    a_din: assert property (p_din) else $error("bad in word");

    c_ecin: cover property (go && req_op == `OP_ECIN);
    c_wr: cover property (bus_dout_en && bus_data_ack);
    c_bcast: cover property (bus_bcast);
endmodule // memctl_checker

bind memctl_unit memctl_checker chk (.*);

/* File: sim/memctl_unit_bench.sv */
// Purpose: self-checking bench for memctl_unit
// Assumes: ext_device answers resource id 4'hA
// Notes:   op flags are gathered until done, then masked
`timescale 1ns/10ps
`include "memctl_defs.vh"

module memctl_unit_bench;
    reg         clk_sys = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    reg         req = 1'h0, data_xlate_enable = 1'h1, instr_xlate_enable = 1'h1;
    reg         bat_prot_viol = 1'h0, tlb_prot_viol = 1'h0, dc_hit = 1'h0;
    reg  [3:0]  reg_addr = 4'h0, req_op = 4'h0, req_seg = 4'h0, slow = 4'h0;
    reg  [31:0] reg_wdata = 32'h0, req_ea = 32'h0, req_pa = 32'h0;
    reg  [31:0] req_src = 32'h0, a, d;
    reg  [1:0]  dc_state = 2'h0, st;
    reg  [5:0]  ctl = 6'h20;
    reg  [7:0]  seen;
    wire        busy, done, ctx_sync, arch_update, fetch_redirect, dc_inval;
    wire        dc_writeback, touch_fill, bus_req, bus_tbst, bus_write;
    wire        bus_bcast, bus_dout_en, bus_addr_ack, bus_data_ack;
    wire [31:0] reg_rdata, result, bus_addr, bus_dout, bus_din;
    wire [2:0]  exc_code, bus_tsize;
    wire [1:0]  dc_new_state;
    integer     fails = 0, comparisons = 0, lat, i;

    memctl_unit uut (.*);
    ext_device dev (.*);

    always #10 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                $display("unexpected %s expected %h seen %h", name, exp, got);
                fails = fails + 1;
            end
        end
    endtask

    task reg_write(input [3:0] ad, input [31:0] wd);
        begin
            @(posedge clk_sys);
            reg_addr  <= ad;
            reg_wdata <= wd;
            reg_wr    <= 1'h1;
            @(posedge clk_sys);
            reg_wr    <= 1'h0;
        end
    endtask

    task reg_read(input [3:0] ad, input [31:0] exp);
        begin
            @(posedge clk_sys);
            reg_addr <= ad;
            reg_rd   <= 1'h1;
            @(posedge clk_sys);
            reg_rd   <= 1'h0;
            #1;
            chk("reg_rdata", exp, reg_rdata);
        end
    endtask

    // flags: bcast wb inval fill redirect arch sync bus_req
    task do_op(input [3:0] op, input [31:0] ea, input [31:0] src,
               input [3:0] seg, input [2:0] exc, input [7:0] fm,
               input [7:0] fe);
        begin
            @(posedge clk_sys);
            {data_xlate_enable, bat_prot_viol, tlb_prot_viol} <= ctl[5:3];
            {dc_hit, dc_state} <= ctl[2:0];
            instr_xlate_enable <= ctl[5];
            req_op  <= op;
            req_ea  <= ea;
            req_pa  <= ea;
            req_src <= src;
            req_seg <= seg;
            req     <= 1'h1;
            @(posedge clk_sys);
            req  <= 1'h0;
            seen = 8'h0;
            st   = 2'h3;
            lat  = -1;
            do begin
                if (lat >= 0)
                    @(posedge clk_sys);
                #1;
                lat  = lat + 1;
                seen = seen | {bus_bcast, dc_writeback, dc_inval, touch_fill,
                               fetch_redirect, arch_update, ctx_sync, bus_req};
                if (dc_inval === 1'h1)
                    st = dc_new_state;
            end while (done !== 1'h1 && lat < 100);
            chk("done", 32'h1, {31'h0, done});
            chk("exc_code", {29'h0, exc}, {29'h0, exc_code});
            chk("flags", {24'h0, fe & fm}, {24'h0, seen & fm});
        end
    endtask

    task report_and_stop;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        reg_read(`ADDR_CONFIG0, `CFG_RESET);
        reg_read(`ADDR_EXT_ACCESS, `EAR_RESET);
        reg_read(4'h3, 32'h0);
        reg_write(`ADDR_EXT_ACCESS, 32'h5000000A);
        reg_read(`ADDR_EXT_ACCESS, 32'h5000000A);
        do_op(`OP_TOUCH, 32'h40, 32'h0, 4'h2, `EXC_NONE, 8'h10, 8'h10);
        ctl = 6'h00;
        do_op(`OP_MTSEG, 32'h0, 32'h80000055, 4'h1, `EXC_NONE, 8'h01, 8'h00);
        do_op(`OP_MTSEG, 32'h0, 32'h00001234, 4'h2, `EXC_NONE, 8'h01, 8'h00);
        do_op(`OP_MFSEG, 32'h0, 32'h0, 4'h2, `EXC_NONE, 8'h01, 8'h00);
        chk("result", 32'h00001234, result);
        reg_read(`ADDR_SEG_BASE + 4'h1, 32'h80000055);
        ctl = 6'h20; // ec ops only with data translation on
        reg_write(`ADDR_CONFIG0, 32'h4);
        do_op(`OP_MFSEG, 32'h0, 32'h0, 4'h2, `EXC_NONE, 8'h01, 8'h00);
        chk("result", 32'h00001234, result);
        for (i = 0; i < 2; i = i + 1) begin
            slow = i[0] ? 4'h3 : 4'h0;
            a = i[0] ? 32'h18 : 32'h14;
            d = i[0] ? 32'h5A5AA5A5 : 32'hCAFEF00D;
            do_op(`OP_ECOUT, a, d, 4'h2, `EXC_NONE, 8'h01, 8'h01);
            do_op(`OP_ECIN, a, 32'h0, 4'h2, `EXC_NONE, 8'h01, 8'h01);
            chk("result", d, result);
        end
        for (i = 1; i < 4; i = i + 1) begin
            a = 32'h10 | i;
            do_op(`OP_ECIN, a, 32'h0, 4'h2, `EXC_ALIGN, 8'h01, 8'h00);
            do_op(`OP_ECOUT, a, 32'h0, 4'h2, `EXC_ALIGN, 8'h01, 8'h00);
        end
        do_op(`OP_ECOUT, 32'h10, 32'h0, 4'h1, `EXC_DSTORE, 8'h01, 8'h00);
        do_op(`OP_ECIN, 32'h10, 32'h0, 4'h1, `EXC_DSTORE, 8'h01, 8'h00);
        reg_write(`ADDR_CONFIG0, 32'h1);
        for (i = 0; i < 2; i = i + 1) begin
            a = i[0] ? `OP_TOUCHST : `OP_TOUCH;
            do_op(a[3:0], 32'h40, 32'h0, 4'h2, `EXC_NONE, 8'h11, 8'h00);
            chk("latency", 32'h0, lat);
        end
        ctl = 6'h26;
        do_op(`OP_DCINV, 32'h40, 32'h0, 4'h2, `EXC_NONE, 8'hE0, 8'h20);
        chk("state", {30'h0, `STATE_INVALID}, {30'h0, st});
        reg_write(`ADDR_CONFIG0, 32'h1A);
        ctl = 6'h25;
        do_op(`OP_DCINV, 32'h40, 32'h0, 4'h2, `EXC_NONE, 8'hE0, 8'hA0);
        chk("state", {30'h0, `STATE_INVALID}, {30'h0, st});
        do_op(`OP_DCINV, 32'h40, 32'h0, 4'h1, `EXC_NONE, 8'hE0, 8'h00);
        ctl = 6'h3D;
        do_op(`OP_DCINV, 32'h40, 32'h0, 4'h2, `EXC_DSTORE, 8'h60, 8'h00);
        ctl = 6'h2D;
        do_op(`OP_DCINV, 32'h40, 32'h0, 4'h2, `EXC_DSTORE, 8'h60, 8'h00);
        do_op(`OP_SYSCALL, 32'h0, 32'h0, 4'h0, `EXC_SYSCALL, 8'h02, 8'h02);
        do_op(`OP_RETINT, 32'h0, 32'h0, 4'h0, `EXC_NONE, 8'h0E, 8'h0E);
        // last fault syscall, idle, 26 ops taken
        reg_read(`ADDR_STATUS, 32'h000D001A);
        report_and_stop;
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        fails = fails + 1;
        report_and_stop;
    end
endmodule // memctl_unit_bench

/* File: src/memctl_defs.vh */
// Purpose: constants for the external-control and memory-control unit
// Assumes: one clock, synchronous active-high reset
// Notes:   register port addresses are word indices
`ifndef MEMCTL_DEFS_VH
`define MEMCTL_DEFS_VH

// ----------------------------------------------------------------
// op codes on the request port
// ----------------------------------------------------------------
`define OP_ECIN      4'h1
`define OP_ECOUT     4'h2
`define OP_TOUCH     4'h3
`define OP_TOUCHST   4'h4
`define OP_DCINV     4'h5
`define OP_SYSCALL   4'h6
`define OP_RETINT    4'h7
`define OP_MTSEG     4'h8
`define OP_MFSEG     4'h9

// ----------------------------------------------------------------
// exception codes
// ----------------------------------------------------------------
`define EXC_NONE     3'h0
`define EXC_ALIGN    3'h1
`define EXC_DSTORE   3'h2
`define EXC_SYSCALL  3'h3

// ----------------------------------------------------------------
// register port map
// ----------------------------------------------------------------
`define ADDR_EXT_ACCESS  4'h0
`define ADDR_CONFIG0     4'h1
`define ADDR_STATUS      4'h2
`define ADDR_SEG_BASE    4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EAR_RID_HI       3
`define EAR_RID_LO       0
`define CFG_TOUCH_NOOP   0
`define CFG_ADDR_BCAST   1
`define CFG_SHADOW_SEG   2
`define CFG_DC_DISABLE   3
`define CFG_DC_LOCK      4
`define SEG_DIRECT_STORE 31
`define ALIGN_MASK       32'h00000003
`define XFER_WORD_SIZE   3'h4
`define CFG_RESET        32'h00000000
`define EAR_RESET        32'h00000000
`define STATE_INVALID    2'h0
`define STATE_EXCL       2'h1
`define STATE_MOD        2'h2

`endif

/* File: src/memctl_unit.v */
// Purpose: external-control bus access and memory-control instructions
// Assumes: one operation at a time; req only while busy is low
// Notes:   cache tag lookup is outside; hit and state come in with req
`timescale 1ns/10ps
`include "memctl_defs.vh"

module memctl_unit (
    input  wire        clk_sys,
    input  wire        rst,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // operation request
    input  wire        req,
    input  wire [3:0]  req_op,
    input  wire [31:0] req_ea,
    input  wire [31:0] req_pa,
    input  wire [31:0] req_src,
    input  wire [3:0]  req_seg,
    input  wire        data_xlate_enable,
    input  wire        instr_xlate_enable,
    input  wire        bat_prot_viol,
    input  wire        tlb_prot_viol,
    input  wire        dc_hit,
    input  wire [1:0]  dc_state,
    output wire        busy,
    output reg         done,
    output reg  [31:0] result,
    output reg  [2:0]  exc_code,
    output reg         ctx_sync,
    output reg         arch_update,
    output reg         fetch_redirect,
    output reg         dc_inval,
    output reg  [1:0]  dc_new_state,
    output reg         dc_writeback,
    output reg         touch_fill,
    // system bus
    output reg         bus_req,
    output reg  [31:0] bus_addr,
    output reg         bus_tbst,
    output reg  [2:0]  bus_tsize,
    output reg         bus_write,
    output reg         bus_bcast,
    output reg  [31:0] bus_dout,
    output reg         bus_dout_en,
    input  wire        bus_addr_ack,
    input  wire        bus_data_ack,
    input  wire [31:0] bus_din
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_ADDR = 4'b0010;
    localparam ST_DATA = 4'b0100;
    localparam ST_RET  = 4'b1000;

    reg [3:0]  state_ff;
    reg [3:0]  nxt_state;
    reg [31:0] external_access_reg_ff;
    reg [31:0] impl_config_reg0_ff;
    reg        op_in_ff;
    reg [15:0] op_count_ff;
    reg [2:0]  last_exc_ff;

    wire        touch_noop_bit        = impl_config_reg0_ff[`CFG_TOUCH_NOOP];
    wire        addr_broadcast_enable = impl_config_reg0_ff[`CFG_ADDR_BCAST];
    wire        shadow_seg_read_bit   = impl_config_reg0_ff[`CFG_SHADOW_SEG];
    wire        dc_disable            = impl_config_reg0_ff[`CFG_DC_DISABLE];
    wire        dc_lock               = impl_config_reg0_ff[`CFG_DC_LOCK];
    wire [3:0]  resource_id =
        external_access_reg_ff[`EAR_RID_HI:`EAR_RID_LO];

    // ------------------------------------------------------------
    // segment registers
    // ------------------------------------------------------------
    wire        seg_wr = req && state_ff == ST_IDLE
                         && req_op == `OP_MTSEG;
    wire [3:0]  seg_rd_idx = (reg_rd && reg_addr >= `ADDR_SEG_BASE) ?
                             {1'b0, reg_addr[2:0]} : req_seg;
    wire [31:0] seg_rd_data;

    // move ops never look at either translation enable
    seg_file u_seg (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .wr_en     (seg_wr),
        .wr_idx    (req_seg),
        .wr_data   (req_src),
        .rd_idx    (seg_rd_idx),
        .rd_shadow (shadow_seg_read_bit),
        .rd_data   (seg_rd_data)
    );

    wire seg_direct_store_bit = seg_rd_data[`SEG_DIRECT_STORE];
    wire misaligned = |(req_ea & `ALIGN_MASK);
    wire is_ec = req_op == `OP_ECIN || req_op == `OP_ECOUT;
    wire is_touch = req_op == `OP_TOUCH || req_op == `OP_TOUCHST;

    assign busy = state_ff != ST_IDLE;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            external_access_reg_ff <= `EAR_RESET;
            impl_config_reg0_ff    <= `CFG_RESET;
            reg_rdata              <= 32'h00000000;
        end else begin
            if (reg_wr && reg_addr == `ADDR_EXT_ACCESS)
                external_access_reg_ff <= reg_wdata;
            if (reg_wr && reg_addr == `ADDR_CONFIG0)
                impl_config_reg0_ff <= reg_wdata;
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_EXT_ACCESS: reg_rdata <= external_access_reg_ff;
                    `ADDR_CONFIG0:    reg_rdata <= impl_config_reg0_ff;
                    `ADDR_STATUS:     reg_rdata <= {11'h000, last_exc_ff,
                                                    state_ff[1:0],
                                                    op_count_ff};
                    default: begin
                        if (reg_addr >= `ADDR_SEG_BASE)
                            reg_rdata <= seg_rd_data;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req && is_ec && !misaligned && !seg_direct_store_bit)
                    nxt_state = ST_ADDR;
                else if (req && req_op == `OP_RETINT)
                    nxt_state = ST_RET;
            end
            ST_ADDR: if (bus_addr_ack) nxt_state = ST_DATA;
            ST_DATA: if (bus_data_ack) nxt_state = ST_IDLE;
            ST_RET:  nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_ff       <= ST_IDLE;
            op_in_ff       <= 1'b0;
            op_count_ff    <= 16'h0000;
            last_exc_ff    <= `EXC_NONE;
            done           <= 1'b0;
            result         <= 32'h00000000;
            exc_code       <= `EXC_NONE;
            ctx_sync       <= 1'b0;
            arch_update    <= 1'b0;
            fetch_redirect <= 1'b0;
            dc_inval       <= 1'b0;
            dc_new_state   <= `STATE_INVALID;
            dc_writeback   <= 1'b0;
            touch_fill     <= 1'b0;
            bus_req        <= 1'b0;
            bus_addr       <= 32'h00000000;
            bus_tbst       <= 1'b0;
            bus_tsize      <= 3'h0;
            bus_write      <= 1'b0;
            bus_bcast      <= 1'b0;
            bus_dout       <= 32'h00000000;
            bus_dout_en    <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            done           <= 1'b0;
            exc_code       <= `EXC_NONE;
            ctx_sync       <= 1'b0;
            arch_update    <= 1'b0;
            fetch_redirect <= 1'b0;
            dc_inval       <= 1'b0;
            dc_writeback   <= 1'b0;
            touch_fill     <= 1'b0;
            bus_bcast      <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (req) begin
                        op_count_ff <= op_count_ff + 16'h0001;
                        case (req_op)
                            `OP_ECIN, `OP_ECOUT: begin
                                if (misaligned) begin
                                    done        <= 1'b1;
                                    exc_code    <= `EXC_ALIGN;
                                    last_exc_ff <= `EXC_ALIGN;
                                end else if (seg_direct_store_bit) begin
                                    done        <= 1'b1;
                                    exc_code    <= `EXC_DSTORE;
                                    last_exc_ff <= `EXC_DSTORE;
                                end else begin
                                    // undefined pa if translation off
                                    bus_req   <= 1'b1;
                                    bus_addr  <= req_pa;
                                    bus_tbst  <= resource_id[3];
                                    bus_tsize <= resource_id[2:0];
                                    bus_write <= req_op == `OP_ECOUT;
                                    op_in_ff  <= req_op == `OP_ECIN;
                                    bus_dout  <= req_src;
                                end
                            end
                            `OP_TOUCH, `OP_TOUCHST: begin
                                done <= 1'b1;
                                touch_fill <= !touch_noop_bit
                                    && !seg_direct_store_bit
                                    && !dc_hit && !dc_disable
                                    && !dc_lock
                                    && !bat_prot_viol && !tlb_prot_viol;
                            end
                            `OP_DCINV: begin
                                done <= 1'b1;
                                if (seg_direct_store_bit) begin
                                    done <= 1'b1;
                                end else if (bat_prot_viol) begin
                                    exc_code    <= `EXC_DSTORE;
                                    last_exc_ff <= `EXC_DSTORE;
                                end else if (tlb_prot_viol) begin
                                    exc_code    <= `EXC_DSTORE;
                                    last_exc_ff <= `EXC_DSTORE;
                                end else begin
                                    // ignores disable and lock
                                    dc_inval     <= dc_hit;
                                    dc_new_state <= `STATE_INVALID;
                                    bus_bcast <= addr_broadcast_enable;
                                    bus_addr  <= req_pa;
                                end
                            end
                            `OP_SYSCALL: begin
                                done        <= 1'b1;
                                ctx_sync    <= 1'b1;
                                exc_code    <= `EXC_SYSCALL;
                                last_exc_ff <= `EXC_SYSCALL;
                            end
                            `OP_RETINT: begin
                                ctx_sync    <= 1'b1;
                                arch_update <= 1'b1;
                            end
                            `OP_MTSEG: begin
                                done <= 1'b1;
                            end
                            `OP_MFSEG: begin
                                done   <= 1'b1;
                                result <= seg_rd_data;
                            end
                            default: begin
                                done <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_ADDR: begin
                    bus_tsize <= resource_id[2:0];
                    if (bus_addr_ack) begin
                        bus_req     <= 1'b0;
                        bus_dout_en <= bus_write;
                    end
                end
                ST_DATA: begin
                    if (bus_data_ack) begin
                        done        <= 1'b1;
                        bus_dout_en <= 1'b0;
                        bus_write   <= 1'b0;
                        if (op_in_ff)
                            result <= bus_din;
                    end
                end
                ST_RET: begin
                    done           <= 1'b1;
                    fetch_redirect <= 1'b1;
                end
                default: begin
                    done <= 1'b0;
                end
            endcase
        end
    end

    // word size is implied by the op; xfer_size is an internal wire only, on no port
    wire [2:0] xfer_size = `XFER_WORD_SIZE;
    wire       unused_ok = ^{xfer_size, instr_xlate_enable, is_touch,
                             data_xlate_enable, dc_state};
endmodule // memctl_unit

/* File: src/seg_file.v */
// Purpose: segment registers, architected and shadow copies
// Assumes: written only by the move-to-segment operation
// Notes:   both copies written together, read selectable
`timescale 1ns/10ps
`include "memctl_defs.vh"

module seg_file (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        wr_en,
    input  wire [3:0]  wr_idx,
    input  wire [31:0] wr_data,
    input  wire [3:0]  rd_idx,
    input  wire        rd_shadow,
    output wire [31:0] rd_data
);
    reg [31:0] seg_ff    [0:15];
    reg [31:0] shadow_ff [0:15];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_seg
            always @(posedge clk_sys) begin
                if (rst) begin
                    seg_ff[g]    <= 32'h00000000;
                    shadow_ff[g] <= 32'h00000000;
                end else if (wr_en && wr_idx == g) begin
                    seg_ff[g]    <= wr_data;
                    shadow_ff[g] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data = rd_shadow ? shadow_ff[rd_idx] : seg_ff[rd_idx];
endmodule // seg_file
